// ==== src/cap_pkg.sv ====
package cap_pkg;

  typedef enum logic [2:0] {FMT_LJ, FMT_RJ, FMT_I2S, FMT_DSPA, FMT_DSPB} cap_fmt_t;

  localparam logic [5:0]  WL_16         = 6'd16;
  localparam logic [5:0]  WL_20         = 6'd20;
  localparam logic [5:0]  WL_24         = 6'd24;
  localparam logic [5:0]  WL_32         = 6'd32;
  localparam logic [6:0]  POS_MAX       = 7'd127;
  localparam logic [10:0] ZERO_RUN      = 11'd1024;
  localparam logic [10:0] MUTE_HARD     = 11'd1024;
  localparam int          MUTE_TAU_LOG2 = 6;
  localparam int          CLK_PERIOD_PS = 5000;
  localparam int          BCLK_HALF_PS  = 40000;
  localparam logic [7:0]  BCLK_HALF_CYC = 8'(BCLK_HALF_PS / CLK_PERIOD_PS);

  function automatic logic [5:0] cap_wl(input logic [1:0] code, input cap_fmt_t fmt);
    case (code)
      2'd0:    return WL_16;
      2'd1:    return WL_20;
      2'd2:    return WL_24;
      default: return (fmt == FMT_RJ) ? WL_24 : WL_32;
    endcase
  endfunction : cap_wl

  function automatic logic [31:0] cap_mask(input logic [5:0] wl);
    return (wl >= WL_32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << wl) - 32'h0000_0001);
  endfunction : cap_mask

  function automatic logic [23:0] cap_to24(input logic [31:0] w, input logic [5:0] wl);
    logic [31:0] t;
    t = (wl > WL_24) ? (w >> (wl - WL_24)) : (w << (WL_24 - wl));
    return t[23:0];
  endfunction : cap_to24

endpackage : cap_pkg

// ==== src/cap_dac_rx.sv ====
module cap_dac_rx (
  input  wire logic              sclk,
  input  wire logic              rst_b,
  input  wire logic              din,
  input  wire logic              wsc,
  input  wire cap_pkg::cap_fmt_t fmt_async,
  input  wire logic [5:0]        wl_async,
  output logic [31:0]            left_q,
  output logic [31:0]            right_q,
  output logic                   done_q
);
  import cap_pkg::*;

  // Config is quasi-static; a level sync is enough
  logic [8:0] cfg1_q;
  logic [8:0] cfg2_q;
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      cfg1_q <= '0;
      cfg2_q <= '0;
    end else begin
      cfg1_q <= {fmt_async, wl_async};
      cfg2_q <= cfg1_q;
    end
  end

  cap_fmt_t          fmt;
  logic [5:0]        wl;
  logic              wsc_q;
  logic [6:0]        pos_q;
  logic [31:0]       sr_q;
  logic              dsp;
  logic              start;
  logic              isl;
  logic [6:0]        pos;
  logic signed [7:0] k;
  logic signed [7:0] w8;
  logic [31:0]       sr_d;

  assign fmt = cap_fmt_t'(cfg2_q[8:6]);
  assign wl  = cfg2_q[5:0];

  always_comb begin
    dsp   = (fmt == FMT_DSPA) || (fmt == FMT_DSPB);
    start = dsp ? (wsc && !wsc_q) : (wsc != wsc_q);
    pos   = start ? 7'd0 : ((pos_q == POS_MAX) ? pos_q : pos_q + 7'd1);
    k     = $signed({1'b0, pos}) - (((fmt == FMT_I2S) || (fmt == FMT_DSPA)) ? 8'sd1 : 8'sd0);
    w8    = $signed({2'b00, wl});
    isl   = (fmt == FMT_I2S) ? !wsc : wsc;
    sr_d  = {sr_q[30:0], din};
  end

  // Sampled on the active link edge only
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      wsc_q   <= 1'b0;
      pos_q   <= '0;
      sr_q    <= '0;
      left_q  <= '0;
      right_q <= '0;
      done_q  <= 1'b0;
    end else begin
      wsc_q <= wsc;
      pos_q <= pos;
      sr_q  <= sr_d;
      if (fmt == FMT_RJ) begin
        if (wsc != wsc_q) begin
          if (wsc_q) begin
            left_q <= sr_q & cap_mask(wl);
          end else begin
            right_q <= sr_q & cap_mask(wl);
            done_q  <= !done_q;
          end
        end
      end else if (dsp) begin
        if (k == w8 - 8'sd1) begin
          left_q <= sr_d & cap_mask(wl);
        end else if (k == w8 + w8 - 8'sd1) begin
          right_q <= sr_d & cap_mask(wl);
          done_q  <= !done_q;
        end
      end else if (k == w8 - 8'sd1) begin
        if (isl) begin
          left_q <= sr_d & cap_mask(wl);
        end else begin
          right_q <= sr_d & cap_mask(wl);
          done_q  <= !done_q;
        end
      end
    end
  end

endmodule : cap_dac_rx

// ==== src/cap_audio_port.sv ====
module cap_audio_port (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              mode_pin,
  input  wire logic              chip_select_or_format_pin,
  input  wire logic              serial_clock_or_wordlen_pin,
  input  wire logic              serial_data_or_deemph_pin,
  input  wire logic              dac_clock_master_select,
  input  wire logic              adc_clock_master_select,
  input  wire logic              dac_bitclk_polarity,
  input  wire logic              adc_bitclk_polarity,
  input  wire cap_pkg::cap_fmt_t sw_format,
  input  wire logic [1:0]        sw_wordlen,
  input  wire logic              sw_deemph,
  input  wire logic              infinite_zero_mute_enable,
  input  wire logic              mute_pin_i,
  input  wire logic              mute_pin_undriven,
  output logic                   mute_pin_o,
  output logic                   mute_pin_oe,
  input  wire logic              dac_bit_clock_i,
  output logic                   dac_bit_clock_o,
  output logic                   dac_bit_clock_oe,
  input  wire logic              dac_word_clock_i,
  output logic                   dac_word_clock_o,
  output logic                   dac_word_clock_oe,
  input  wire logic              adc_bit_clock_i,
  output logic                   adc_bit_clock_o,
  output logic                   adc_bit_clock_oe,
  input  wire logic              adc_word_clock_i,
  output logic                   adc_word_clock_o,
  output logic                   adc_word_clock_oe,
  input  wire logic              dac_data_in,
  output logic                   adc_data_out,
  input  wire logic [23:0]       adc_left_in,
  input  wire logic [23:0]       adc_right_in,
  output logic [23:0]            dac_left_out,
  output logic [23:0]            dac_right_out,
  output logic                   dac_out_valid,
  output logic                   hard_midpoint,
  output logic                   zero_run_mute_latch,
  output logic                   deemph_enable
);
  import cap_pkg::*;
  // ==========================================================
  // Pin synchronisers
  logic [7:0] sync1_q;
  logic       hw_s, fp_s, wp_s, dm_s, mp_s, un_s, ab_s, al_s;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= '0;
      {hw_s, fp_s, wp_s, dm_s, mp_s, un_s, ab_s, al_s} <= '0;
    end else begin
      sync1_q <= {mode_pin, chip_select_or_format_pin, serial_clock_or_wordlen_pin,
                  serial_data_or_deemph_pin, mute_pin_i, mute_pin_undriven,
                  adc_bit_clock_i, adc_word_clock_i};
      {hw_s, fp_s, wp_s, dm_s, mp_s, un_s, ab_s, al_s} <= sync1_q;
    end
  end

  // ==========================================================
  // Format and clocking selection
  cap_fmt_t   fmt_q;
  logic [5:0] wl_q;
  logic       dac_ms_q, adc_ms_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fmt_q         <= FMT_LJ;
      wl_q          <= WL_24;
      deemph_enable <= 1'b0;
      dac_ms_q      <= 1'b0;
      adc_ms_q      <= 1'b0;
    end else if (hw_s) begin
      fmt_q         <= fp_s ? FMT_I2S : FMT_RJ;
      wl_q          <= ({fp_s, wp_s} == 2'b01) ? WL_20 :
                       ({fp_s, wp_s} == 2'b10) ? WL_16 : WL_24;
      deemph_enable <= dm_s;
      dac_ms_q      <= 1'b0;
      adc_ms_q      <= 1'b0;
    end else begin
      fmt_q         <= sw_format;
      wl_q          <= cap_wl(sw_wordlen, sw_format);
      deemph_enable <= sw_deemph;
      dac_ms_q      <= dac_clock_master_select;
      adc_ms_q      <= adc_clock_master_select;
    end
  end

  // ==========================================================
  // Master clock generators, DAC index 0, ADC index 1
  logic       ms_v  [2];
  logic       gb_q  [2];
  logic       gl_q  [2];
  logic [7:0] gdiv_q[2];
  logic [5:0] gbit_q[2];
  logic       gdsp;
  assign ms_v[0] = dac_ms_q;
  assign ms_v[1] = adc_ms_q;
  assign gdsp = (fmt_q == FMT_DSPA) || (fmt_q == FMT_DSPB);

  for (genvar g = 0; g < 2; g++) begin : g_mst
    logic [5:0] nb;
    assign nb = gbit_q[g] + 6'd1;
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        gdiv_q[g] <= '0;
        gb_q[g]   <= 1'b0;
        gbit_q[g] <= '0;
        gl_q[g]   <= 1'b0;
      end else if (!ms_v[g]) begin
        gdiv_q[g] <= '0;
        gb_q[g]   <= 1'b0;
      end else if (gdiv_q[g] == BCLK_HALF_CYC - 8'd1) begin
        gdiv_q[g] <= '0;
        gb_q[g]   <= !gb_q[g];
        // Word clock moves on the falling bit clock edge
        if (gb_q[g]) begin
          gbit_q[g] <= nb;
          gl_q[g]   <= gdsp ? (nb == 6'd0) : !nb[5];
        end
      end else begin
        gdiv_q[g] <= gdiv_q[g] + 8'd1;
      end
    end
  end

  assign dac_bit_clock_o   = gb_q[0];
  assign dac_word_clock_o  = gl_q[0];
  assign adc_bit_clock_o   = gb_q[1];
  assign adc_word_clock_o  = gl_q[1];
  assign dac_bit_clock_oe  = dac_ms_q;
  assign dac_word_clock_oe = dac_ms_q;
  assign adc_bit_clock_oe  = adc_ms_q;
  assign adc_word_clock_oe = adc_ms_q;

  // ==========================================================
  // DAC receive on its own bit clock
  // Polarity must only change while the link is idle
  logic        dac_sclk;
  logic [31:0] rx_l, rx_r;
  logic        rx_tgl;
  assign dac_sclk = dac_bit_clock_i ^ dac_bitclk_polarity;

  cap_dac_rx u_rx (
    .sclk      (dac_sclk),
    .rst_b     (rst_b),
    .din       (dac_data_in),
    .wsc       (dac_word_clock_i),
    .fmt_async (fmt_q),
    .wl_async  (wl_q),
    .left_q    (rx_l),
    .right_q   (rx_r),
    .done_q    (rx_tgl)
  );

  // Toggle crossing; the word pair stays stable a whole word after it
  logic        tg1_q, tg2_q, tg3_q, new_q;
  logic [23:0] sl_q, sr_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tg1_q <= 1'b0;
      tg2_q <= 1'b0;
      tg3_q <= 1'b0;
      new_q <= 1'b0;
      sl_q  <= '0;
      sr_q  <= '0;
    end else begin
      tg1_q <= rx_tgl;
      tg2_q <= tg1_q;
      tg3_q <= tg2_q;
      new_q <= tg2_q ^ tg3_q;
      if (tg2_q ^ tg3_q) begin
        sl_q <= cap_to24(rx_l, wl_q);
        sr_q <= cap_to24(rx_r, wl_q);
      end
    end
  end

  // ==========================================================
  // Zero detect, mute and output
  logic        zero, mute_req, zdet_en, hard;
  logic [10:0] zcnt_q, mcnt_q;
  assign zero     = (sl_q == 24'h00_0000) && (sr_q == 24'h00_0000);
  assign zdet_en  = infinite_zero_mute_enable || un_s;
  assign mute_req = mp_s || (zero_run_mute_latch && infinite_zero_mute_enable);
  assign hard     = mute_req && zdet_en && (mcnt_q == MUTE_HARD);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      zcnt_q              <= '0;
      zero_run_mute_latch <= 1'b0;
    end else if (new_q) begin
      zcnt_q <= !zero ? 11'd0 : ((zcnt_q == ZERO_RUN) ? zcnt_q : zcnt_q + 11'd1);
      if (!zero) begin
        zero_run_mute_latch <= 1'b0;
      end else if (zcnt_q == ZERO_RUN - 11'd1) begin
        zero_run_mute_latch <= 1'b1;
      end
    end
  end

  // Latch drives the pin weakly; a floating pin becomes the flag output
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mute_pin_o  <= 1'b0;
      mute_pin_oe <= 1'b0;
    end else begin
      mute_pin_o  <= zero_run_mute_latch;
      mute_pin_oe <= zero_run_mute_latch || un_s;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mcnt_q        <= '0;
      dac_left_out  <= '0;
      dac_right_out <= '0;
      dac_out_valid <= 1'b0;
      hard_midpoint <= 1'b0;
    end else begin
      dac_out_valid <= new_q;
      if (new_q) begin
        mcnt_q <= !mute_req ? 11'd0 : ((mcnt_q == MUTE_HARD) ? mcnt_q : mcnt_q + 11'd1);
        hard_midpoint <= hard;
        if (!mute_req) begin
          dac_left_out  <= sl_q;
          dac_right_out <= sr_q;
        end else if (hard) begin
          dac_left_out  <= '0;
          dac_right_out <= '0;
        end else begin
          // One-pole decay, coefficient 1/64 per sample
          dac_left_out  <= dac_left_out - 24'($signed(dac_left_out) >>> MUTE_TAU_LOG2);
          dac_right_out <= dac_right_out - 24'($signed(dac_right_out) >>> MUTE_TAU_LOG2);
        end
      end
    end
  end

  // ==========================================================
  // ADC transmit, oversampled bit clock
  logic              ab_q, al_q, adc_edge, adsp, astart, aleft, abit;
  logic [6:0]        apos_q, alen_q, apos;
  logic signed [7:0] ak, kk, w8;
  logic [31:0]       aword;
  logic [23:0]       hl_q, hr_q;

  always_comb begin
    adc_edge = adc_bitclk_polarity ? (ab_s && !ab_q) : (!ab_s && ab_q);
    adsp     = (fmt_q == FMT_DSPA) || (fmt_q == FMT_DSPB);
    astart   = adsp ? (al_s && !al_q) : (al_s != al_q);
    apos     = astart ? 7'd0 : ((apos_q == POS_MAX) ? apos_q : apos_q + 7'd1);
    w8       = $signed({2'b00, wl_q});
    if (fmt_q == FMT_RJ) begin
      ak = $signed({1'b0, apos}) - ($signed({1'b0, alen_q}) - w8);
    end else if ((fmt_q == FMT_I2S) || (fmt_q == FMT_DSPA)) begin
      ak = $signed({1'b0, apos}) - 8'sd1;
    end else begin
      ak = $signed({1'b0, apos});
    end
    aleft = (fmt_q == FMT_I2S) ? !al_s : al_s;
    kk    = (adsp && (ak >= w8)) ? ak - w8 : ak;
    aword = {((adsp ? (ak < w8) : aleft) ? (astart ? adc_left_in : hl_q) : hr_q), 8'h00};
    abit  = (kk >= 8'sd0) && (kk < w8) ? aword[5'(8'sd31 - kk)] : 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ab_q         <= 1'b0;
      al_q         <= 1'b0;
      apos_q       <= '0;
      alen_q       <= '0;
      hl_q         <= '0;
      hr_q         <= '0;
      adc_data_out <= 1'b0;
    end else begin
      ab_q <= ab_s;
      if (adc_edge) begin
        al_q         <= al_s;
        apos_q       <= apos;
        adc_data_out <= abit;
        if (astart) begin
          alen_q <= (apos_q == POS_MAX) ? apos_q : apos_q + 7'd1;
        end
        if (astart && (adsp || aleft)) begin
          hl_q <= adc_left_in;
          hr_q <= adc_right_in;
        end
      end
    end
  end

  // ==========================================================
  // Checks
  property p_hw_slave;
    @(posedge clk) disable iff (!rst_b) hw_s |=> !dac_bit_clock_oe && !adc_word_clock_oe;
  endproperty
  a_hw_slave: assert property (p_hw_slave) else $error("master clocks in hardware mode");

  property p_float_out;
    @(posedge clk) disable iff (!rst_b) un_s |=> mute_pin_oe;
  endproperty
  a_float_out: assert property (p_float_out) else $error("floating mute pin not driven");

  property p_decay;
    @(posedge clk) disable iff (!rst_b) new_q && mute_req && !hard |=>
      dac_left_out == $past(dac_left_out) - 24'($signed($past(dac_left_out)) >>> 6);
  endproperty
  a_decay: assert property (p_decay) else $error("soft mute decay wrong");

  property p_hard;
    @(posedge clk) disable iff (!rst_b) new_q && hard |=> dac_left_out == 24'h00_0000
      && dac_right_out == 24'h00_0000 && hard_midpoint;
  endproperty
  a_hard: assert property (p_hard) else $error("no hard midpoint");

  property p_release;
    @(posedge clk) disable iff (!rst_b) new_q && !mp_s && !infinite_zero_mute_enable
      |=> dac_left_out == $past(sl_q) && dac_out_valid;
  endproperty
  a_release: assert property (p_release) else $error("unmuted sample not passed");

  property p_zset;
    @(posedge clk) disable iff (!rst_b) new_q && zero && zcnt_q == 11'd1023
      |=> zero_run_mute_latch ##2 mute_pin_o;
  endproperty
  a_zset: assert property (p_zset) else $error("zero run latch not set");

  property p_zclr;
    @(posedge clk) disable iff (!rst_b) new_q && !zero |=> !zero_run_mute_latch;
  endproperty
  a_zclr: assert property (p_zclr) else $error("zero run latch not cleared");

  property p_hwfmt;
    @(posedge clk) disable iff (!rst_b) hw_s && fp_s && !wp_s |=> fmt_q == FMT_I2S
      && wl_q == 6'd16;
  endproperty
  a_hwfmt: assert property (p_hwfmt) else $error("hardware format decode wrong");

  property p_deemph;
    @(posedge clk) disable iff (!rst_b) hw_s |=> deemph_enable == $past(dm_s);
  endproperty
  a_deemph: assert property (p_deemph) else $error("de-emphasis not from pin");

  property p_adc_edge;
    @(posedge clk) disable iff (!rst_b) $changed(adc_data_out) |->
      $past(ab_q) != adc_bitclk_polarity && $past(ab_s) == adc_bitclk_polarity;
  endproperty
  a_adc_edge: assert property (p_adc_edge) else $error("ADC data off edge");

endmodule : cap_audio_port

// ==== tb/cap_ctrl_model.sv ====
module cap_ctrl_model (
  input  wire cap_pkg::cap_fmt_t fmt,
  input  wire logic [5:0]        wl,
  input  wire logic              pol,
  input  wire logic              adc_in,
  output logic                   bclk,
  output logic                   wclk,
  output logic                   dout,
  output logic [31:0]            adc_word
);
  timeunit 1ns;
  timeprecision 1ps;
  import cap_pkg::*;
  // ==========================================
  // Link timing, 125 ns bit period
  localparam int H = 32;
  logic ph = 1'b0;
  assign bclk = ph ^ pol;
  initial begin
    wclk = 1'b0;
    dout = 1'b0;
    adc_word = '0;
  end
  function automatic logic lvl(input int k);
    if (fmt == FMT_I2S) return k >= H;
    if (fmt == FMT_DSPA || fmt == FMT_DSPB) return k == 0;
    return k < H;
  endfunction : lvl
  function automatic int bmap(input int k);
    int w, o, bl, br;
    w = int'(wl);
    o = (fmt == FMT_I2S || fmt == FMT_DSPA) ? 1 : 0;
    bl = (fmt == FMT_RJ) ? H - w : o;
    br = (fmt == FMT_RJ) ? 2 * H - w : (o + ((lvl(1) == lvl(2) && !lvl(0)) ? H : w));
    if (fmt == FMT_LJ || fmt == FMT_I2S) br = H + o;
    if (k >= bl && k < bl + w) return bl + w - 1 - k;
    if (k >= br && k < br + w) return 64 + br + w - 1 - k;
    return -1;
  endfunction : bmap
  // Controller moves data on the inactive edge
  task automatic slot(input logic lv, input logic d, input bit cap);
    #62.5;
    ph = 1'b0;
    wclk = lv;
    dout = d;
    #62.5;
    ph = 1'b1;
    if (cap) adc_word = {adc_word[30:0], adc_in};
  endtask : slot
  // Clock stands still between bursts; idle data toggles so no stale bit
  task automatic send_pair(input logic [31:0] l, input logic [31:0] r, input bit lead,
                           input bit tail);
    int k, b, n;
    n = (fmt == FMT_DSPA || fmt == FMT_DSPB) ? 6 * int'(wl) : 2 * H;
    if (lead) repeat (3) slot(lvl(n - 1), ~dout, 1'b0);
    adc_word = '0;
    for (k = 0; k < n; k++) begin
      b = bmap(k);
      if (b < 0) slot(lvl(k), ~dout, 1'b0);
      else if (b < 64) slot(lvl(k), l[b], 1'b1);
      else slot(lvl(k), r[b - 64], 1'b0);
    end
    if (tail) begin
      slot(lvl(0), ~dout, 1'b0);
      slot(lvl(1), ~dout, 1'b0);
      #62.5;
      ph = 1'b0;
      dout = ~dout;
    end
  endtask : send_pair
endmodule : cap_ctrl_model

// ==== tb/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cap_pkg::*;
  logic        clk, rst_b, mode_pin, chip_select_or_format_pin, serial_clock_or_wordlen_pin;
  logic        serial_data_or_deemph_pin, dac_clock_master_select, adc_clock_master_select;
  logic        sw_deemph, infinite_zero_mute_enable, mute_drv, mute_pin_undriven, pol;
  logic        mute_pin_o, mute_pin_oe, dac_bit_clock_o, dac_bit_clock_oe, dac_word_clock_o;
  logic        dac_word_clock_oe, adc_bit_clock_o, adc_bit_clock_oe, adc_word_clock_o;
  logic        adc_word_clock_oe, adc_data_out, dac_out_valid, hard_midpoint;
  logic        zero_run_mute_latch, deemph_enable, lk_bclk, lk_wclk, lk_dout;
  logic [1:0]  sw_wordlen;
  logic [5:0]  m_wl;
  logic [23:0] adc_l, adc_r, dac_left_out, dac_right_out, el, er, pl, pr;
  logic [31:0] adc_word;
  logic [23:0] ql[$], qr[$];
  cap_fmt_t    sw_format, m_fmt;
  cap_fmt_t    fl[6] = '{FMT_LJ, FMT_RJ, FMT_I2S, FMT_DSPA, FMT_DSPB, FMT_RJ};
  int          wc[6] = '{0, 1, 2, 3, 2, 3};
  int          hw_wl[4] = '{24, 20, 16, 24};
  int          failures, checks, nval;
  bit          armed, mute_run;

  cap_audio_port DUT (
    .clk, .rst_b, .mode_pin, .chip_select_or_format_pin, .serial_clock_or_wordlen_pin,
    .serial_data_or_deemph_pin, .dac_clock_master_select, .adc_clock_master_select,
    .dac_bitclk_polarity(pol), .adc_bitclk_polarity(pol), .sw_format, .sw_wordlen, .sw_deemph,
    .infinite_zero_mute_enable, .mute_pin_i(mute_drv), .mute_pin_undriven, .mute_pin_o,
    .mute_pin_oe, .dac_bit_clock_i(lk_bclk), .dac_bit_clock_o, .dac_bit_clock_oe,
    .dac_word_clock_i(lk_wclk), .dac_word_clock_o, .dac_word_clock_oe,
    .adc_bit_clock_i(lk_bclk), .adc_bit_clock_o, .adc_bit_clock_oe, .adc_word_clock_i(lk_wclk),
    .adc_word_clock_o, .adc_word_clock_oe, .dac_data_in(lk_dout), .adc_data_out,
    .adc_left_in(adc_l), .adc_right_in(adc_r), .dac_left_out, .dac_right_out, .dac_out_valid,
    .hard_midpoint, .zero_run_mute_latch, .deemph_enable
  );
  cap_ctrl_model u_ctrl (.fmt(m_fmt), .wl(m_wl), .pol, .adc_in(adc_data_out), .bclk(lk_bclk),
    .wclk(lk_wclk), .dout(lk_dout), .adc_word);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ==========================================
  // Checking helpers
  task automatic chk(input bit ok, input string msg);
    checks++;
    if (!ok) begin
      failures++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic close_out;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  function automatic logic [23:0] to24(input logic [31:0] w, input int n);
    if (n > 24) return w[31:8];
    return 24'(w << (24 - n));
  endfunction : to24
  // Samples seen before arming come from the burst start toggle and are skipped
  always @(posedge clk) begin
    if (armed && dac_out_valid === 1'b1) begin
      nval++;
      chk(ql.size() > 0, "unexpected sample");
      if (ql.size() > 0) begin
        el = ql.pop_front();
        er = qr.pop_front();
        if (mute_drv) begin
          el = pl - 24'($signed(pl) >>> 6);
          er = pr - 24'($signed(pr) >>> 6);
        end
        chk(dac_left_out === el && dac_right_out === er, "dac sample pair");
        pl = el;
        pr = er;
      end
      if (mute_run) mute_drv <= (nval >= 3 && nval < 6);
    end
  end
  task automatic burst(input cap_fmt_t f, input int w, input int n);
    logic [31:0] l, r, m;
    m = (w == 32) ? 32'hFFFF_FFFF : (32'h0000_0001 << w) - 32'h0000_0001;
    tick();
    m_fmt = f;
    m_wl = 6'(w);
    adc_l = 24'($urandom);
    adc_r = 24'($urandom);
    armed = 1'b0;
    nval = 0;
    fork
      #625 armed = 1'b1;
    join_none
    for (int i = 0; i < n; i++) begin
      l = (i == 0) ? 32'h0000_0001 << (w - 1) : $urandom & m;
      r = (i == 0) ? m : $urandom & m;
      ql.push_back(to24(l, w));
      qr.push_back(to24(r, w));
      if (i > 0) begin
        tick();
        adc_l = 24'($urandom);
      end
      u_ctrl.send_pair(l, r, i == 0, i == n - 1);
    end
    for (int t = 0; t < 20 && ql.size() > 0; t++) tick();
    chk(ql.size() == 0, "dac sample missing");
    if (w <= 24) chk(adc_word === 32'(adc_l >> (24 - w)), "adc left word");
    armed = 1'b0;
    ql.delete();
    qr.delete();
  endtask : burst
  // ==========================================
  // Main sequence
  initial begin
    int  w;
    logic b0, b1;
    {rst_b, mode_pin, chip_select_or_format_pin, serial_clock_or_wordlen_pin} = '0;
    {serial_data_or_deemph_pin, dac_clock_master_select, adc_clock_master_select} = '0;
    {sw_deemph, infinite_zero_mute_enable, mute_drv, mute_pin_undriven, pol} = '0;
    {sw_wordlen, adc_l, adc_r, armed, mute_run} = '0;
    sw_format = FMT_LJ;
    m_fmt = FMT_LJ;
    m_wl = 6'd24;
    void'($urandom(32'h684A_2C86));
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) tick();
    chk({dac_bit_clock_oe, dac_word_clock_oe, adc_bit_clock_oe} === 3'b000, "slave");
    for (int i = 0; i < 6; i++) begin
      tick();
      sw_format = fl[i];
      sw_wordlen = 2'(wc[i]);
      w = (wc[i] == 3) ? ((fl[i] == FMT_RJ) ? 24 : 32) : 16 + 4 * wc[i];
      burst(fl[i], w, 2);
    end
    tick();
    sw_format = FMT_LJ;
    sw_wordlen = 2'd2;
    pol = 1'b1;
    sw_deemph = 1'b1;
    burst(FMT_LJ, 24, 2);
    chk(deemph_enable === 1'b1, "software deemphasis");
    tick();
    pol = 1'b0;
    mute_run = 1'b1;
    burst(FMT_LJ, 24, 8);
    mute_run = 1'b0;
    chk(hard_midpoint === 1'b0 && zero_run_mute_latch === 1'b0, "no hard mute");
    tick();
    chk(mute_pin_oe === 1'b0, "mute pin driven with latch clear");
    mute_pin_undriven = 1'b1;
    repeat (4) tick();
    chk(mute_pin_oe === 1'b1 && mute_pin_o === 1'b0, "floating mute pin flag");
    mute_pin_undriven = 1'b0;
    tick();
    mode_pin = 1'b1;
    sw_format = FMT_DSPB;
    {dac_clock_master_select, adc_clock_master_select} = 2'b11;
    for (int c = 0; c < 4; c++) begin
      tick();
      chip_select_or_format_pin = c[1];
      serial_clock_or_wordlen_pin = c[0];
      serial_data_or_deemph_pin = c[0];
      burst(c[1] ? FMT_I2S : FMT_RJ, hw_wl[c], 2);
      chk(deemph_enable === c[0], "deemphasis pin");
      chk({dac_bit_clock_oe, adc_word_clock_oe} === 2'b00, "hw slave");
    end
    tick();
    mode_pin = 1'b0;
    repeat (10) @(posedge clk);
    chk({dac_bit_clock_oe, adc_bit_clock_oe, dac_word_clock_oe} === 3'b111, "master");
    b0 = dac_bit_clock_o;
    for (int t = 0; t < 40 && (dac_bit_clock_o === b0 || adc_bit_clock_o === b0); t++) tick();
    chk(dac_bit_clock_o !== b0 && adc_bit_clock_o !== b0, "master bit clocks run");
    b0 = adc_word_clock_o;
    b1 = dac_word_clock_o;
    for (int t = 0; t < 1200 && (adc_word_clock_o === b0 || dac_word_clock_o === b1); t++) tick();
    chk(adc_word_clock_o !== b0 && dac_word_clock_o !== b1, "master word clocks run");
    close_out();
  end
endmodule : tb
